/* core/iie_params.svh */
/*
  Constants of the add-one / block-input execution slice: debug register
  offsets, opcodes, flag bit positions, reset values and buffer depth.
  Assumes it is included by its bare name before the package and modules.
*/
`ifndef IIE_PARAMS_SVH
`define IIE_PARAMS_SVH

// ****************************************
// debug register offsets (4-bit index)
// ****************************************
`define IIE_OFS_GPR_LAST 4'h7
`define IIE_OFS_XLO      4'h8
`define IIE_OFS_XHI      4'h9
`define IIE_OFS_YLO      4'hA
`define IIE_OFS_YHI      4'hB
`define IIE_OFS_PCL      4'hC
`define IIE_OFS_PCH      4'hD
`define IIE_OFS_CTRL     4'hE
`define IIE_OFS_STAT     4'hF

// ****************************************
// register file indices (rrr codes)
// ****************************************
`define IIE_R_CNT   3'h0
`define IIE_R_PORT  3'h1
`define IIE_R_PHI   3'h4
`define IIE_R_PLO   3'h5
`define IIE_R_FLAGS 3'h6
`define IIE_RSEL_MEM 3'h6

// ****************************************
// opcodes
// ****************************************
`define IIE_OP_INC_MEM 8'h34
`define IIE_INC_MASK   8'hC7
`define IIE_INC_PAT    8'h04
`define IIE_PFX_XR     8'hDD
`define IIE_PFX_YR     8'hFD
`define IIE_PFX_ED     8'hED
`define IIE_OP_UP      8'hA2
`define IIE_OP_DN      8'hAA
`define IIE_OP_UP_RPT  8'hB2
`define IIE_OP_DN_RPT  8'hBA

// ****************************************
// flag bit positions and values
// ****************************************
`define IIE_FLG_S  7
`define IIE_FLG_Z  6
`define IIE_FLG_U5 5
`define IIE_FLG_H  4
`define IIE_FLG_U3 3
`define IIE_FLG_PV 2
`define IIE_FLG_N  1
`define IIE_OVF_VAL 8'h7F
`define IIE_NIB_MAX 4'hF

// ****************************************
// reset values, counts, depth
// ****************************************
`define IIE_RST_BYTE   8'h00
`define IIE_RST_WORD   16'h0000
`define IIE_PC_REWIND  16'h0002
`define IIE_FIFO_DEPTH 8

`endif

/* core/iie_pkg.sv */
/*
  Types of the add-one / block-input execution slice.
  Assumes iie_params.svh sits on the include path.
*/
`include "iie_params.svh"

package iie_pkg;

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_FETCH = 4'b0001,
    S_PFX   = 4'b0010,
    S_DISP  = 4'b0011,
    S_MRD   = 4'b0100,
    S_MWR   = 4'b0101,
    S_IORD  = 4'b0110,
    S_IOWR  = 4'b0111,
    S_INTA  = 4'b1000
  } iie_state_t;

  // opcode page selected by a prefix byte
  typedef enum logic [1:0] {
    P_NONE = 2'b00,
    P_XR   = 2'b01,
    P_YR   = 2'b10,
    P_ED   = 2'b11
  } iie_pfx_t;

endpackage : iie_pkg

/* core/iie_inc8.sv */
/*
  Combinational 8-bit add-one with its flag results.
  Assumes the caller picks the operand and stores result and flags.
*/
`include "iie_params.svh"

module iie_inc8
  import iie_pkg::*;
(
  input  wire logic [7:0] i_opnd,
  input  wire logic [7:0] i_flags,
  output logic      [7:0] o_res,
  output logic      [7:0] o_flags
);

  // ****************************************
  // sum and flags
  // ****************************************
  assign o_res = i_opnd + 8'h01;
  // carry bit stays as it was; undocumented bits are left alone too
  always_comb
  begin
    o_flags                = i_flags;
    o_flags[`IIE_FLG_S]    = o_res[7];
    o_flags[`IIE_FLG_Z]    = (o_res == 8'h00);
    o_flags[`IIE_FLG_H]    = (i_opnd[3:0] == `IIE_NIB_MAX);
    o_flags[`IIE_FLG_PV]   = (i_opnd == `IIE_OVF_VAL);
    o_flags[`IIE_FLG_N]    = 1'b0;
  end

endmodule // iie_inc8

/* core/iie_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock, asynchronous active-high reset, DEPTH a power of two.
*/
module iie_fifo
  import iie_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  // ****************************************
  // handshake
  // ****************************************
  assign o_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_valid = (cnt_reg != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_reg[rp_reg];

  // storage is written only on a push, so no reset is needed on it
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= i_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule // iie_fifo

/* core/iie_core.sv */
/*
  Execution slice for 8-bit add-one (register, pointer memory, indexed
  memory) and the block input group, with a debug register port.
  Assumes a synchronous memory/I-O bus on I_REF_CLK; I_WAIT_N and
  I_INT_REQ are asynchronous and are synchronised here.
*/
// Decided for this implementation: the register offsets and the address-and-strobe port.
`include "iie_params.svh"

module iie_core
  import iie_pkg::*;
(
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  output logic      [15:0] O_ADDR,
  output logic      [7:0]  O_DOUT,
  input  wire logic [7:0]  I_DIN,
  output logic             O_MEM_RD,
  output logic             O_MEM_WR,
  output logic             O_IO_RD,
  input  wire logic        I_WAIT_N,
  input  wire logic        I_INT_REQ,
  output logic             O_INT_ACK,
  input  wire logic [3:0]  I_REG_ADDR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_WR,
  input  wire logic        I_REG_RD,
  output logic      [7:0]  O_REG_RDATA
);

  // ****************************************
  // declarations
  // ****************************************
  iie_state_t  state_reg;
  iie_state_t  state_next;
  iie_pfx_t    pfx_reg;
  logic [7:0]  gpr_reg [8];
  logic [15:0] pc_reg;
  logic [15:0] index_x_reg;
  logic [15:0] index_y_reg;
  logic [15:0] addr_reg;
  logic [7:0]  data_reg;
  logic [7:0]  ir_reg;
  logic [7:0]  rdata_reg;
  logic        run_reg;
  logic        wait_m_reg;
  logic        wait_s_reg;
  logic        int_m_reg;
  logic        int_s_reg;
  logic        int_d_reg;
  logic        int_pend_reg;
  logic [15:0] ptr_pair;
  logic [15:0] io_addr;
  logic [15:0] idx_sum;
  logic [7:0]  cnt_dec;
  logic [7:0]  blk_flags;
  logic [7:0]  inc_opnd;
  logic [7:0]  inc_res;
  logic [7:0]  inc_flags;
  logic        is_inc_r;
  logic        is_blk;
  logic        blk_down;
  logic        blk_rpt;
  logic        xfer_ok;
  logic        fetch_ok;
  logic        io_ok;
  logic        st_ok;
  logic        sw_wr;
  logic        fifo_in_rdy;
  logic        fifo_out_vld;
  logic [7:0]  fifo_dout;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // wait and interrupt come from other clocks, so two flops each
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      wait_m_reg <= 1'b1;
      wait_s_reg <= 1'b1;
      int_m_reg  <= 1'b0;
      int_s_reg  <= 1'b0;
      int_d_reg  <= 1'b0;
    end
    else
    begin
      wait_m_reg <= I_WAIT_N;
      wait_s_reg <= wait_m_reg;
      int_m_reg  <= I_INT_REQ;
      int_s_reg  <= int_m_reg;
      int_d_reg  <= int_s_reg;
    end
  end

  // a request edge is held until acknowledged; a new edge beats the clear
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      int_pend_reg <= 1'b0;
    end
    else if (int_s_reg && !int_d_reg)
    begin
      int_pend_reg <= 1'b1;
    end
    else if (state_reg == S_INTA)
    begin
      int_pend_reg <= 1'b0;
    end
  end

  // ****************************************
  // decode helpers
  // ****************************************
  assign ptr_pair = {gpr_reg[`IIE_R_PHI], gpr_reg[`IIE_R_PLO]};
  assign io_addr  = {gpr_reg[`IIE_R_CNT], gpr_reg[`IIE_R_PORT]};
  assign is_inc_r = ((I_DIN & `IIE_INC_MASK) == `IIE_INC_PAT)
                    && (I_DIN[5:3] != `IIE_RSEL_MEM);
  assign is_blk   = (I_DIN == `IIE_OP_UP) || (I_DIN == `IIE_OP_DN)
                    || (I_DIN == `IIE_OP_UP_RPT) || (I_DIN == `IIE_OP_DN_RPT);
  assign blk_down = ir_reg[3];
  assign blk_rpt  = ir_reg[4];
  assign idx_sum  = ((pfx_reg == P_XR) ? index_x_reg : index_y_reg)
                    + {{8{I_DIN[7]}}, I_DIN};
  assign cnt_dec  = gpr_reg[`IIE_R_CNT] - 8'h01;
  assign inc_opnd = (state_reg == S_FETCH) ? gpr_reg[I_DIN[5:3]] : I_DIN;
  assign sw_wr    = I_REG_WR && (state_reg == S_IDLE);

  // flags after a block input step
  always_comb
  begin
    blk_flags            = gpr_reg[`IIE_R_FLAGS];
    blk_flags[`IIE_FLG_Z] = (cnt_dec == 8'h00);
    blk_flags[`IIE_FLG_N] = 1'b1;
    if (ir_reg == `IIE_OP_UP)
    begin
      blk_flags[`IIE_FLG_U5] = cnt_dec[5];
      blk_flags[`IIE_FLG_U3] = cnt_dec[3];
    end
  end

  iie_inc8 u_inc
  (
    .i_opnd  (inc_opnd),
    .i_flags (gpr_reg[`IIE_R_FLAGS]),
    .o_res   (inc_res),
    .o_flags (inc_flags)
  );

  // port bytes queue here before the memory write; a full queue stops the read
  iie_fifo #(.WIDTH(8), .DEPTH(`IIE_FIFO_DEPTH)) u_fifo
  (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_valid (io_ok),
    .o_ready (fifo_in_rdy),
    .i_data  (I_DIN),
    .o_valid (fifo_out_vld),
    .i_ready (st_ok),
    .o_data  (fifo_dout)
  );

  // ****************************************
  // bus drive
  // ****************************************
  // a strobe completes in any cycle where the synced wait reads high
  assign O_MEM_RD  = ((state_reg == S_FETCH) && run_reg && !int_pend_reg)
                     || (state_reg == S_PFX) || (state_reg == S_DISP)
                     || (state_reg == S_MRD);
  assign O_MEM_WR  = (state_reg == S_MWR)
                     || ((state_reg == S_IOWR) && fifo_out_vld);
  assign O_IO_RD   = (state_reg == S_IORD) && fifo_in_rdy;
  assign O_INT_ACK = (state_reg == S_INTA);
  assign xfer_ok   = wait_s_reg;
  assign fetch_ok  = O_MEM_RD && xfer_ok;
  assign io_ok     = O_IO_RD && xfer_ok;
  assign st_ok     = (state_reg == S_IOWR) && fifo_out_vld && xfer_ok;

  always_comb
  begin
    case (state_reg)
      S_FETCH, S_PFX, S_DISP: O_ADDR = pc_reg;
      S_MRD, S_MWR:           O_ADDR = addr_reg;
      S_IORD:                 O_ADDR = io_addr;
      S_IOWR:                 O_ADDR = ptr_pair;
      default:                O_ADDR = `IIE_RST_WORD;
    endcase
  end

  assign O_DOUT = (state_reg == S_MWR) ? data_reg
                : (state_reg == S_IOWR) ? fifo_dout : `IIE_RST_BYTE;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (run_reg)
        begin
          state_next = S_FETCH;
        end
      end
      S_FETCH:
      begin
        // instruction boundary: repeat iterations pass through here too
        if (!run_reg)
        begin
          state_next = S_IDLE;
        end
        else if (int_pend_reg)
        begin
          state_next = S_INTA;
        end
        else if (fetch_ok)
        begin
          if ((I_DIN == `IIE_PFX_XR) || (I_DIN == `IIE_PFX_YR)
              || (I_DIN == `IIE_PFX_ED))
          begin
            state_next = S_PFX;
          end
          else if (I_DIN == `IIE_OP_INC_MEM)
          begin
            state_next = S_MRD;
          end
        end
      end
      S_PFX:
      begin
        if (fetch_ok)
        begin
          if ((pfx_reg == P_ED) && is_blk)
          begin
            state_next = S_IORD;
          end
          else if ((pfx_reg != P_ED) && (I_DIN == `IIE_OP_INC_MEM))
          begin
            state_next = S_DISP;
          end
          else
          begin
            state_next = S_FETCH;
          end
        end
      end
      S_DISP:
      begin
        if (fetch_ok)
        begin
          state_next = S_MRD;
        end
      end
      S_MRD:
      begin
        if (fetch_ok)
        begin
          state_next = S_MWR;
        end
      end
      S_MWR:
      begin
        if (xfer_ok)
        begin
          state_next = S_FETCH;
        end
      end
      S_IORD:
      begin
        if (io_ok)
        begin
          state_next = S_IOWR;
        end
      end
      S_IOWR:
      begin
        if (st_ok)
        begin
          state_next = S_FETCH;
        end
      end
      S_INTA:  state_next = S_FETCH;
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_reg <= S_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // prefix page and second opcode byte
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pfx_reg <= P_NONE;
      ir_reg  <= `IIE_RST_BYTE;
    end
    else if ((state_reg == S_FETCH) && fetch_ok)
    begin
      pfx_reg <= (I_DIN == `IIE_PFX_XR) ? P_XR
               : (I_DIN == `IIE_PFX_YR) ? P_YR
               : (I_DIN == `IIE_PFX_ED) ? P_ED : P_NONE;
    end
    else if ((state_reg == S_PFX) && fetch_ok)
    begin
      ir_reg <= I_DIN;
    end
  end

  // operand address and result byte for the memory forms
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      addr_reg <= `IIE_RST_WORD;
      data_reg <= `IIE_RST_BYTE;
    end
    else if ((state_reg == S_FETCH) && fetch_ok)
    begin
      addr_reg <= ptr_pair;
    end
    else if ((state_reg == S_DISP) && fetch_ok)
    begin
      addr_reg <= idx_sum;
    end
    else if ((state_reg == S_MRD) && fetch_ok)
    begin
      data_reg <= inc_res;
    end
  end

  // ****************************************
  // program counter and index registers
  // ****************************************
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pc_reg <= `IIE_RST_WORD;
    end
    else if (sw_wr && (I_REG_ADDR == `IIE_OFS_PCL))
    begin
      pc_reg[7:0] <= I_REG_WDATA;
    end
    else if (sw_wr && (I_REG_ADDR == `IIE_OFS_PCH))
    begin
      pc_reg[15:8] <= I_REG_WDATA;
    end
    else if (fetch_ok && (state_reg != S_MRD))
    begin
      pc_reg <= pc_reg + 16'h0001;
    end
    else if (st_ok && blk_rpt && (cnt_dec != 8'h00))
    begin
      pc_reg <= pc_reg - `IIE_PC_REWIND;
    end
  end

  // index registers only change from the debug port
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      index_x_reg <= `IIE_RST_WORD;
      index_y_reg <= `IIE_RST_WORD;
    end
    else if (sw_wr)
    begin
      case (I_REG_ADDR)
        `IIE_OFS_XLO: index_x_reg[7:0]  <= I_REG_WDATA;
        `IIE_OFS_XHI: index_x_reg[15:8] <= I_REG_WDATA;
        `IIE_OFS_YLO: index_y_reg[7:0]  <= I_REG_WDATA;
        `IIE_OFS_YHI: index_y_reg[15:8] <= I_REG_WDATA;
        default:      index_x_reg       <= index_x_reg;
      endcase
    end
  end

  // ****************************************
  // general registers and flags
  // ****************************************
  // core writes only happen while running, debug writes only while idle
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < 8; i++)
      begin
        gpr_reg[i] <= `IIE_RST_BYTE;
      end
    end
    else if (sw_wr && (I_REG_ADDR <= `IIE_OFS_GPR_LAST))
    begin
      gpr_reg[I_REG_ADDR[2:0]] <= I_REG_WDATA;
    end
    else if ((state_reg == S_FETCH) && fetch_ok && is_inc_r)
    begin
      gpr_reg[I_DIN[5:3]]    <= inc_res;
      gpr_reg[`IIE_R_FLAGS] <= inc_flags;
    end
    else if ((state_reg == S_MRD) && fetch_ok)
    begin
      gpr_reg[`IIE_R_FLAGS] <= inc_flags;
    end
    else if (st_ok)
    begin
      gpr_reg[`IIE_R_CNT]   <= cnt_dec;
      gpr_reg[`IIE_R_FLAGS] <= blk_flags;
      {gpr_reg[`IIE_R_PHI], gpr_reg[`IIE_R_PLO]} <=
        blk_down ? (ptr_pair - 16'h0001) : (ptr_pair + 16'h0001);
    end
  end

  // ****************************************
  // debug register port
  // ****************************************
  // clearing run only stops at the next instruction boundary
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      run_reg <= 1'b0;
    end
    else if (I_REG_WR && (I_REG_ADDR == `IIE_OFS_CTRL))
    begin
      run_reg <= I_REG_WDATA[0];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rdata_reg <= `IIE_RST_BYTE;
    end
    else if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        `IIE_OFS_XLO:  rdata_reg <= index_x_reg[7:0];
        `IIE_OFS_XHI:  rdata_reg <= index_x_reg[15:8];
        `IIE_OFS_YLO:  rdata_reg <= index_y_reg[7:0];
        `IIE_OFS_YHI:  rdata_reg <= index_y_reg[15:8];
        `IIE_OFS_PCL:  rdata_reg <= pc_reg[7:0];
        `IIE_OFS_PCH:  rdata_reg <= pc_reg[15:8];
        `IIE_OFS_CTRL: rdata_reg <= {7'h00, run_reg};
        `IIE_OFS_STAT: rdata_reg <= {2'h0, fifo_out_vld, int_pend_reg, state_reg};
        default:       rdata_reg <= gpr_reg[I_REG_ADDR[2:0]];
      endcase
    end
  end

  assign O_REG_RDATA = rdata_reg;

endmodule // iie_core

/* sim/iie_mem_model.sv */
/* far-side memory and port model of the execution slice.
   assumes the bench preloads mem directly while the core is idle. */
module iie_mem_model
(
  input  wire logic        i_clk,
  input  wire logic        i_slow,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_dout,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic        i_io_rd,
  output logic      [7:0]  o_din,
  output logic             o_wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:4095];
  logic [15:0] io_log [0:7];
  logic [7:0]  last_reg = 8'h00;
  logic [1:0]  cyc_reg = 2'h0;
  logic        io_prev_reg = 1'b0;
  logic [15:0] prev_addr_reg;
  int          io_count = 0;
  function automatic logic [7:0] io_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  initial
    foreach (mem[k]) mem[k] = 8'h00;
  // a slow port holds wait low three cycles in four
  assign o_wait_n = !i_slow || (cyc_reg == 2'h3);
  // data stand only under a strobe; otherwise the bus toggles
  always_comb
    if (i_io_rd) o_din = io_val(i_addr);
    else if (i_mem_rd) o_din = mem[i_addr[11:0]];
    else o_din = ~last_reg;
  // store writes, log each completed port read with its address
  always @(posedge i_clk)
  begin
    cyc_reg <= cyc_reg + 2'h1;
    last_reg <= o_din;
    io_prev_reg <= i_io_rd;
    prev_addr_reg <= i_addr;
    if (i_mem_wr) mem[i_addr[11:0]] <= i_dout;
    if (io_prev_reg && !i_io_rd)
    begin
      io_log[io_count % 8] <= prev_addr_reg;
      io_count <= io_count + 1;
    end
  end
endmodule // iie_mem_model

/* sim/iie_checker.sv */
/* port-level checker of the execution slice.
   assumes a bind from the bench top; sees core ports only. */
module iie_checker
(
  input wire logic        I_REF_CLK,
  input wire logic        I_RST,
  input wire logic [15:0] O_ADDR,
  input wire logic [7:0]  O_DOUT,
  input wire logic [7:0]  I_DIN,
  input wire logic        O_MEM_RD,
  input wire logic        O_MEM_WR,
  input wire logic        O_IO_RD,
  input wire logic        O_INT_ACK
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  logic        last_io_reg;
  logic [15:0] last_addr_reg;
  logic [7:0]  last_din_reg;
  // last read seen; a write-back must match it
  always_ff @(posedge I_REF_CLK or posedge I_RST)
    if (I_RST)
    begin
      last_io_reg <= 1'b0;
      last_addr_reg <= 16'h0000;
      last_din_reg <= 8'h00;
    end
    else if (O_MEM_RD || O_IO_RD)
    begin
      last_io_reg <= O_IO_RD;
      last_addr_reg <= O_ADDR;
      last_din_reg <= I_DIN;
    end
  chk_one_strobe: assert property ($onehot0({O_MEM_RD, O_MEM_WR, O_IO_RD}))
    else $error("two bus strobes at once");
  chk_io_then_wr: assert property ($fell(O_IO_RD) |-> ##[0:30] O_MEM_WR)
    else $error("port read not followed by store");
  chk_io_addr_hold: assert property (O_IO_RD && $past(O_IO_RD) |-> $stable(O_ADDR))
    else $error("port address moved under strobe");
  chk_wr_hold: assert property (O_MEM_WR && $past(O_MEM_WR) |-> $stable({O_ADDR, O_DOUT}))
    else $error("write moved under strobe");
  chk_inc_addr: assert property ($rose(O_MEM_WR) && !last_io_reg |-> O_ADDR == last_addr_reg)
    else $error("write-back address differs");
  chk_inc_data: assert property ($rose(O_MEM_WR) && !last_io_reg |-> O_DOUT == last_din_reg + 8'h01)
    else $error("write-back not operand plus one");
  chk_io_data: assert property ($rose(O_MEM_WR) && last_io_reg |-> O_DOUT == last_din_reg)
    else $error("stored byte differs from port byte");
  chk_ack_pulse: assert property (O_INT_ACK |=> !O_INT_ACK)
    else $error("acknowledge longer than one cycle");
  chk_ack_bus_idle: assert property (O_INT_ACK |-> !(O_MEM_RD || O_MEM_WR || O_IO_RD))
    else $error("acknowledge during a bus cycle");
  cov_inc_mem: cover property ($rose(O_MEM_WR) && !last_io_reg);
  cov_io_rd: cover property ($fell(O_IO_RD));
  cov_ack: cover property (O_INT_ACK);
endmodule // iie_checker

/* sim/test_incr_block_input_exec.sv */
/* bench of the add-one / block-input slice: register tasks load state,
   the model holds program and data. assumes clearing run stops the core. */
`include "iie_params.svh"
module test_incr_block_input_exec;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, wait_n, int_req, slow, reg_wr, reg_rd, mrd, mwr, iord, ack;
  logic [15:0] addr;
  logic [7:0]  dout, din, rdata, wdata, v;
  logic [3:0]  ra;
  logic [2:0]  r;
  int          fails, check_count, acks, ack_io, base, i;
  logic [7:0]  opv [0:6] = '{8'h7F, 8'hFF, 8'h0F, 8'h00, 8'h80, 8'h3E, 8'h8F};
  iie_core i_dut (.I_REF_CLK(clk), .I_RST(rst), .O_ADDR(addr), .O_DOUT(dout), .I_DIN(din),
    .O_MEM_RD(mrd), .O_MEM_WR(mwr), .O_IO_RD(iord), .I_WAIT_N(wait_n), .I_INT_REQ(int_req),
    .O_INT_ACK(ack), .I_REG_ADDR(ra), .I_REG_WDATA(wdata), .I_REG_WR(reg_wr),
    .I_REG_RD(reg_rd), .O_REG_RDATA(rdata));
  iie_mem_model i_mem (.i_clk(clk), .i_slow(slow), .i_addr(addr), .i_dout(dout),
    .i_mem_rd(mrd), .i_mem_wr(mwr), .i_io_rd(iord), .o_din(din), .o_wait_n(wait_n));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // register port tasks
  // ****************************************
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    ra <= a;
    wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    ra <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(input string n, input logic [3:0] a, input logic [7:0] e);
    rd(a, v);
    check(n, v, e);
  endtask
  task automatic w16(input logic [3:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 4'h1, d[15:8]);
  endtask
  // program at address zero; pc rewound so every run starts there
  task automatic load(input logic [23:0] p);
    i_mem.mem[0] = p[23:16];
    i_mem.mem[1] = p[15:8];
    i_mem.mem[2] = p[7:0];
    w16(`IIE_OFS_PCL, 16'h0000);
  endtask
  // start, let it run, stop, and poll the state until idle
  task automatic run(input int n);
    int k;
    wr(`IIE_OFS_CTRL, 8'h01);
    repeat (n) @(posedge clk);
    wr(`IIE_OFS_CTRL, 8'h00);
    v = 8'hFF;
    for (k = 0; k < 50 && v[3:0] != 4'h0; k++) rd(`IIE_OFS_STAT, v);
    check("stop", v[3:0], 4'h0);
  endtask
  task automatic setio(input logic [7:0] c, p, input logic [15:0] ptr, input logic [7:0] f);
    wr(4'h0, c);
    wr(4'h1, p);
    w16(4'h4, {ptr[7:0], ptr[15:8]});
    wr(4'h6, f);
    base = i_mem.io_count;
  endtask
  function automatic logic [7:0] iflags(input logic [7:0] op, f);
    logic [7:0] res;
    res = op + 8'h01;
    return {res[7], res == 8'h00, f[5], op[3:0] == 4'hF, f[3], op == 8'h7F, 1'b0, f[0]};
  endfunction
  task automatic test_done();
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // acknowledge count and how many port reads had completed by then
  always @(posedge clk)
    if (ack === 1'b1)
    begin
      acks++;
      ack_io = i_mem.io_count - base;
    end
  initial
  begin
    repeat (10000) @(posedge clk);
    fails++;
    test_done();
  end
  initial
  begin
    {rst, int_req, slow, reg_wr, reg_rd, ra, wdata} = {1'b1, 16'h0000};
    {fails, check_count, acks, ack_io, base} = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk_rd("ctrl", `IIE_OFS_CTRL, 8'h00);
    wr(`IIE_OFS_STAT, 8'hFF);
    chk_rd("stat", `IIE_OFS_STAT, 8'h00);
    // every register code once, operands on the flag corners; old flags
    // alternate all-set and subtract-only so each flag is seen to move
    for (i = 0; i < 7; i++)
    begin
      r = (i == 6) ? 3'h7 : i[2:0];
      wr({1'b0, r}, opv[i]);
      wr(4'h6, i[0] ? 8'hFF : 8'h02);
      load({2'b00, r, 3'b100, 16'h0000});
      run(20);
      chk_rd("inc_reg", {1'b0, r}, opv[i] + 8'h01);
      chk_rd("inc_flags", 4'h6, iflags(opv[i], i[0] ? 8'hFF : 8'h02));
    end
    w16(4'h4, 16'h1002);
    i_mem.mem[12'h210] = 8'hFF;
    wr(4'h6, 8'h01);
    load(24'h340000);
    run(20);
    check("inc_mem", i_mem.mem[12'h210], 8'h00);
    w16(`IIE_OFS_XLO, 16'h0305);
    w16(`IIE_OFS_YLO, 16'h0400);
    i_mem.mem[12'h303] = 8'h7F;
    i_mem.mem[12'h405] = 8'h0F;
    load(24'hDD34FE);
    run(30);
    load(24'hFD3405);
    run(30);
    check("inc_ix", i_mem.mem[12'h303], 8'h80);
    check("inc_iy", i_mem.mem[12'h405], 8'h10);
    chk_rd("idx_flags", 4'h6, iflags(8'h0F, iflags(8'h7F, iflags(8'hFF, 8'h01))));
    setio(8'h29, 8'h17, 16'h0500, 8'hD5);
    load(24'hEDA200);
    run(30);
    check("up_mem", i_mem.mem[12'h500], i_mem.io_val(16'h2917));
    check("up_port", i_mem.io_log[base % 8], 16'h2917);
    chk_rd("up_cnt", 4'h0, 8'h28);
    chk_rd("up_ptr", 4'h5, 8'h01);
    chk_rd("up_flags", 4'h6, 8'hBF);
    setio(8'h01, 8'h33, 16'h0600, 8'h00);
    load(24'hEDAA00);
    run(30);
    check("dn_mem", i_mem.mem[12'h600], i_mem.io_val(16'h0133));
    chk_rd("dn_cnt", 4'h0, 8'h00);
    chk_rd("dn_ptr", 4'h4, 8'h05);
    rd(4'h6, v);
    check("dn_flags", v & 8'hD7, 8'h42);
    // slow port and an interrupt arriving mid-repeat
    slow <= 1'b1;
    setio(8'h03, 8'h20, 16'h0700, 8'h00);
    load(24'hEDB200);
    fork
      run(200);
      begin
        repeat (12) @(posedge clk);
        int_req <= 1'b1;
      end
    join
    check("rpt_n", i_mem.io_count - base, 16'h0003);
    for (i = 0; i < 3; i++)
    begin
      check("rpt_mem", i_mem.mem[12'h700 + i], i_mem.io_val({8'h03 - i[7:0], 8'h20}));
      check("rpt_port", i_mem.io_log[(base + i) % 8], {8'h03 - i[7:0], 8'h20});
    end
    check("ack_n", acks, 16'h0001);
    check("ack_mid", ack_io < 3, 16'h0001);
    slow <= 1'b0;
    int_req <= 1'b0;
    setio(8'h02, 8'h44, 16'h0800, 8'h00);
    load(24'hEDBA00);
    run(60);
    check("rdn_mem", i_mem.mem[12'h7FF], i_mem.io_val(16'h0144));
    chk_rd("rdn_cnt", 4'h0, 8'h00);
    chk_rd("rdn_ptr", 4'h5, 8'hFE);
    test_done();
  end
endmodule // test_incr_block_input_exec
bind iie_core iie_checker i_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .O_ADDR(O_ADDR),
  .O_DOUT(O_DOUT), .I_DIN(I_DIN), .O_MEM_RD(O_MEM_RD), .O_MEM_WR(O_MEM_WR),
  .O_IO_RD(O_IO_RD), .O_INT_ACK(O_INT_ACK));
